// file: test/logic_timer_flipflop_tb.sv
/*
 Self-checking bench for logic_timer_flipflop: bus, logic, timer, flip-flop.
 Assumes the shortened prescaler values given at the instance.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("BAD %0t %s", $time, m); end end
module logic_timer_flipflop_tb;
    localparam int TK = 10;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [15:0] s; logic e;} row_t;
    logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0, lo, tm, ff;
    logic [31:0] wdat = 32'h0, rdat;
    logic [15:0] want = 16'h0000, sig;
    wire logic [11:0] obs = {ff, tm, lo};
    int err_count = 0, n_tests = 0;
    // Logic unit 0 rows, then flip-flop 0 rows (set from input 8, reset from 9)
    row_t rows [21] = '{'{8'h00, 32'h00153210, 16'h000F, 1'b1},
        '{8'h00, 32'h00193210, 16'h0007, 1'b0}, '{8'h00, 32'h01193210, 16'h0007, 1'b1},
        '{8'h00, 32'h00283210, 16'h000E, 1'b0}, '{8'h00, 32'h003F3210, 16'h0007, 1'b1},
        '{8'h00, 32'h00223210, 16'h000C, 1'b0}, '{8'h00, 32'h002A3210, 16'h0008, 1'b1},
        '{8'hD0, 32'h098, 16'h0100, 1'b1}, '{8'hD0, 32'h098, 16'h0300, 1'b0},
        '{8'hD0, 32'h098, 16'h0200, 1'b0}, '{8'hD0, 32'h098, 16'h0300, 1'b0},
        '{8'hD0, 32'h198, 16'h0200, 1'b0}, '{8'hD0, 32'h198, 16'h0300, 1'b1},
        '{8'hD0, 32'h198, 16'h0100, 1'b1}, '{8'hD0, 32'h198, 16'h0300, 1'b1},
        '{8'hD0, 32'h298, 16'h0000, 1'b1}, '{8'hD0, 32'h298, 16'h0300, 1'b1},
        '{8'hD0, 32'h298, 16'h0000, 1'b1}, '{8'hD0, 32'h298, 16'h0200, 1'b0},
        '{8'hD0, 32'h298, 16'h0000, 1'b0}, '{8'hD0, 32'h298, 16'h0300, 1'b0}};
    always #2.5 clk = ~clk;
    status_source src (.clk(clk), .rst_n(rst_n), .want(want), .sig_q(sig));
    logic_timer_flipflop #(.TICK_CYCLES(TK), .SAMPLE_CYCLES(8)) dut (.CLK_SYS(clk),
        .ARST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .SIG_IN(sig),
        .LOGIC_OUT(lo), .TIMER_OUT(tm), .FLIPFLOP_OUT(ff));
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] q);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 40);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (ack !== 1'b1) begin
            err_count++;
            $display("BAD %0t bus hang", $time);
            stop_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hF, q);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hF, q);
        `CHK(q, e, "read value")
    endtask
    task automatic sets(input logic [15:0] v);
        @(posedge clk);
        want <= v;
    endtask
    task automatic waitfor(input int b, input logic v, input int lo_c, input int hi_c);
        int n;
        n = 0;
        while (obs[b] !== v && n <= hi_c) begin
            @(posedge clk);
            n++;
        end
        `CHK(n >= lo_c && n <= hi_c, 1'b1, "output timing")
        if (n > hi_c) stop_test();
    endtask
    initial begin
        logic [31:0] q;
        logic [31:0] v;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(8'h00, 32'h00150000);
        rdchk(8'h08, 32'h0);
        rdchk(8'h40, 32'h0);
        rdchk(8'hD0, 32'h0);
        wr(8'hE8, 32'hFFFFFFFF);
        rdchk(8'hE8, 32'h0);
        wr(8'hE4, 32'h00000FFF);
        rdchk(8'hE4, 32'h0);
        wr(8'hB8, 32'h00012345);
        bus(1'b1, 8'hB8, 32'hFFFFFFFF, 4'h1, q);
        rdchk(8'hB8, 32'h000123FF);
        $display("reset test done");
        for (int i = 0; i < 21; i++) begin
            wr(rows[i].a, rows[i].d);
            sets(rows[i].s);
            repeat (24) @(posedge clk);
            if (rows[i].a == 8'hD0)
                `CHK(obs[8], rows[i].e, "ff row")
            else
                `CHK(obs[0], rows[i].e, "logic row")
        end
        $display("table test done");
        wr(8'h00, 32'h0);
        wr(8'h04, 32'd3);
        wr(8'h08, 32'd3);
        sets(16'h0001);
        waitfor(0, 1'b1, 2 * TK, 3 * TK + 6);
        sets(16'h0000);
        repeat (12) @(posedge clk);
        bus(1'b0, 8'h0C, 32'h0, 4'hF, q);
        `CHK(q == 32'd1 || q == 32'd2, 1'b1, "logic elapsed")
        waitfor(0, 1'b0, 0, 3 * TK + 6);
        wr(8'h40, 32'h14);
        wr(8'h44, 32'd3);
        sets(16'h0010);
        waitfor(4, 1'b1, 2 * TK, 3 * TK + 6);
        rdchk(8'hC0, 32'd3);
        sets(16'h0000);
        waitfor(4, 1'b0, 0, 3);
        rdchk(8'hC0, 32'h0);
        wr(8'h40, 32'h24);
        wr(8'h48, 32'd2);
        wr(8'h4C, 32'd3);
        sets(16'h0010);
        waitfor(4, 1'b1, 0, 4);
        waitfor(4, 1'b0, TK, 2 * TK + 6);
        waitfor(4, 1'b1, 2 * TK, 3 * TK + 6);
        waitfor(4, 1'b0, TK, 2 * TK + 6);
        waitfor(4, 1'b1, 2 * TK, 3 * TK + 6);
        sets(16'h0000);
        waitfor(4, 1'b0, 0, 4);
        wr(8'h40, 32'h34);
        wr(8'h48, 32'd3);
        sets(16'h0010);
        waitfor(4, 1'b1, 0, 4);
        sets(16'h0000);
        waitfor(4, 1'b0, 2 * TK - 3, 3 * TK + 6);
        sets(16'h0010);
        sets(16'h0000);
        repeat (15) @(posedge clk);
        sets(16'h0010);
        sets(16'h0000);
        waitfor(4, 1'b0, 2 * TK - 3, 3 * TK + 6);
        sets(16'h0010);
        repeat (50) @(posedge clk);
        `CHK(obs[4], 1'b1, "on-time held")
        sets(16'h0000);
        waitfor(4, 1'b0, 0, 4);
        wr(8'h40, 32'h04);
        sets(16'h0010);
        repeat (40) @(posedge clk);
        `CHK(obs[4], 1'b0, "disabled timer")
        rdchk(8'hC0, 32'h0);
        wr(8'h40, 32'h14);
        wr(8'h44, 32'd8);
        wr(8'h80, 32'h14);
        wr(8'h84, 32'd8);
        repeat (35) @(posedge clk);
        bus(1'b0, 8'hC0, 32'h0, 4'hF, q);
        wr(8'hE0, 32'h1);
        bus(1'b0, 8'hC0, 32'h0, 4'hF, v);
        `CHK(v >= q && q != 32'h0, 1'b1, "count across set switch")
        sets(16'h0000);
        wr(8'h30, 32'h00000005);
        wr(8'hA0, 32'h00000015);
        wr(8'hD4, 32'h00000005);
        sets(16'h0020);
        repeat (24) @(posedge clk);
        `CHK(obs, 12'h248, "units apart")
        $display("timer test done");
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK(obs, 12'h000, "outputs in reset")
        rst_n <= 1'b1;
        rdchk(8'h44, 32'h0);
        $display("second reset done");
        stop_test();
    end
endmodule
`default_nettype wire

// file: test/ltf_asserts.sv
/*
 Port checks for logic_timer_flipflop, bound to every instance.
 Assumes one clock domain and a slave that acks one cycle after a request.
*/
`timescale 1ns/1ps
`default_nettype none
module ltf_asserts #(
    parameter TICK_CYCLES = 20000000,
    parameter SAMPLE_CYCLES = 1600000
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    // Bus
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    // Functions
    input wire logic [15:0] SIG_IN,
    input wire logic [3:0] LOGIC_OUT,
    input wire logic [3:0] TIMER_OUT,
    input wire logic [3:0] FLIPFLOP_OUT
);
    logic [15:0] sig_q;
    logic [3:0] ff_q;
    logic [31:0] rise_age_q;
    logic [31:0] ff_age_q;
    wire logic [11:0] stat = {FLIPFLOP_OUT, TIMER_OUT, LOGIC_OUT};
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!ARST_N);
    // Age since any status input rose, and since a flip-flop output moved
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            sig_q <= 16'h0000;
            ff_q <= 4'h0;
            rise_age_q <= 32'h0;
            ff_age_q <= 32'hFFFF;
        end else begin
            sig_q <= SIG_IN;
            ff_q <= FLIPFLOP_OUT;
            if (|(SIG_IN & ~sig_q)) begin
                rise_age_q <= 32'h0;
            end else if (rise_age_q < 32'hFFFF) begin
                rise_age_q <= rise_age_q + 32'h1;
            end
            if (FLIPFLOP_OUT != ff_q) begin
                ff_age_q <= 32'h0;
            end else if (ff_age_q < 32'hFFFF) begin
                ff_age_q <= ff_age_q + 32'h1;
            end
        end
    end
    chk_ack_follows_req: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("request not acknowledged in the next cycle");
    chk_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("acknowledge longer than one cycle");
    chk_ack_has_req: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
        else $error("acknowledge without request");
    chk_rdata_holds: assert property (!WB_ACK_O |-> $stable(WB_DAT_O))
        else $error("read data moved between requests");
    chk_unmapped_zero: assert property (WB_ACK_O && $past(!WB_WE_I && WB_ADR_I >= 8'hE8)
        |-> WB_DAT_O == 32'h0) else $error("unmapped read not zero");
    chk_status_mirror: assert property (WB_ACK_O && $past(!WB_WE_I && WB_ADR_I[7:2] == 6'h39)
        |-> WB_DAT_O[31:12] == 20'h0 && (WB_DAT_O[11:0] == $past(stat)
        || WB_DAT_O[11:0] == $past(stat, 2))) else $error("status read differs from outputs");
    chk_reset_quiet: assert property ($rose(ARST_N) |-> !WB_ACK_O && stat == 12'h000)
        else $error("outputs not low after reset");
    chk_ff_needs_rise: assert property (
        $changed(FLIPFLOP_OUT) |-> rise_age_q <= 2 * SAMPLE_CYCLES + 4)
        else $error("flip-flop moved without an input rise");
    chk_ff_on_samples: assert property (
        $changed(FLIPFLOP_OUT) |-> ff_age_q >= SAMPLE_CYCLES - 1)
        else $error("flip-flop moved twice in one sample interval");
endmodule
bind logic_timer_flipflop ltf_asserts #(
    .TICK_CYCLES(TICK_CYCLES),
    .SAMPLE_CYCLES(SAMPLE_CYCLES)
) chk (
    .CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .SIG_IN(SIG_IN), .LOGIC_OUT(LOGIC_OUT), .TIMER_OUT(TIMER_OUT),
    .FLIPFLOP_OUT(FLIPFLOP_OUT)
);
`default_nettype wire

// file: test/status_source.sv
/*
 Source of the sixteen status signals that feed the block.
 Assumes the bench sets the wanted levels; they reach the pins one edge later.
*/
`timescale 1ns/1ps
`default_nettype none
module status_source (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Wanted levels and the pins
    input wire logic [15:0] want,
    output logic [15:0] sig_q
);
    // Levels move just after an edge, like any source in this domain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sig_q <= 16'h0000;
        end else begin
            sig_q <= want;
        end
    end
endmodule
`default_nettype wire

// file: verilog/logic_timer_flipflop.v
/*
 Four logic expression units, four timers and four SR flip-flops driven by
 sixteen internal status signals, configured over a classic Wishbone slave.
 Assumes status inputs synchronous to CLK_SYS and a single-cycle bus master.
*/
`timescale 1ns/1ps
`include "ltf_map.vh"
`default_nettype none

module logic_timer_flipflop #(
    parameter TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS,
    parameter SAMPLE_CYCLES = `SAMPLE_PERIOD_NS / `CLK_PERIOD_NS
) (
    // Clock and reset
    input wire CLK_SYS,
    input wire ARST_N,
    // Wishbone slave
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [7:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    output reg [31:0] WB_DAT_O,
    output reg WB_ACK_O,
    // Status signals and function outputs
    input wire [15:0] SIG_IN,
    output wire [3:0] LOGIC_OUT,
    output wire [3:0] TIMER_OUT,
    output wire [3:0] FLIPFLOP_OUT
);

    localparam [31:0] TICK_LAST32 = TICK_CYCLES - 1;
    localparam [31:0] SAMPLE_LAST32 = SAMPLE_CYCLES - 1;
    localparam [`TICK_CNT_W-1:0] TICK_LAST = TICK_LAST32[`TICK_CNT_W-1:0];
    localparam [`SAMPLE_CNT_W-1:0] SAMPLE_LAST = SAMPLE_LAST32[`SAMPLE_CNT_W-1:0];

    function ev_op;
        input a;
        input b;
        input [1:0] op;
        begin
            case (op)
                `OP_AND: ev_op = a & b;
                `OP_OR: ev_op = a | b;
                `OP_XOR: ev_op = a ^ b;
                default: ev_op = a;
            endcase
        end
    endfunction

    function ev_expr;
        input [3:0] v;
        input [1:0] o1;
        input [1:0] o2;
        input [1:0] o3;
        input ord;
        reg p12;
        reg p34;
        begin
            p12 = (o1 == `OP_END) ? v[0] : ev_op(v[0], v[1], o1);
            if (ord == `ORDER_CHAIN) begin
                ev_expr = p12;
                if (o1 != `OP_END && o2 != `OP_END) begin
                    ev_expr = ev_op(p12, v[2], o2);
                    if (o3 != `OP_END)
                        ev_expr = ev_op(ev_op(p12, v[2], o2), v[3], o3);
                end
            end else begin
                p34 = (o3 == `OP_END) ? v[2] : ev_op(v[2], v[3], o3);
                ev_expr = (o1 == `OP_END || o2 == `OP_END) ? p12 : ev_op(p12, p34, o2);
            end
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] upd;
        input [3:0] sel;
        integer k;
        begin
            merge = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (sel[k])
                    merge[k*8 +: 8] = upd[k*8 +: 8];
            end
        end
    endfunction

    // Configuration storage
    reg [`LCFG_W-1:0] lg_cfg_q [0:3];
    reg [`TIME_W-1:0] lg_set_q [0:3];
    reg [`TIME_W-1:0] lg_res_q [0:3];
    reg [`TCFG_W-1:0] tm_cfg_q [0:7];
    reg [`TIME_W-1:0] tm_dly_q [0:7];
    reg [`TIME_W-1:0] tm_t1_q [0:7];
    reg [`TIME_W-1:0] tm_t2_q [0:7];
    reg [`FCFG_W-1:0] ff_cfg_q [0:3];
    reg act_set_q;

    wire [4*`TIME_W-1:0] lg_val;
    wire [4*`TIME_W-1:0] tm_val;

    // Tick prescalers
    reg [`TICK_CNT_W-1:0] tick_cnt_q;
    reg [`SAMPLE_CNT_W-1:0] samp_cnt_q;
    wire tick = (tick_cnt_q == TICK_LAST);
    wire samp = (samp_cnt_q == SAMPLE_LAST);

    always @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            tick_cnt_q <= {`TICK_CNT_W{1'b0}};
            samp_cnt_q <= {`SAMPLE_CNT_W{1'b0}};
        end else begin
            tick_cnt_q <= tick ? {`TICK_CNT_W{1'b0}} : tick_cnt_q + 1'b1;
            samp_cnt_q <= samp ? {`SAMPLE_CNT_W{1'b0}} : samp_cnt_q + 1'b1;
        end
    end

    // Bus decode
    wire [5:0] idx = WB_ADR_I[7:2];
    wire [1:0] region = idx[5:4];
    wire [1:0] unit = idx[3:2];
    wire [1:0] sub = idx[1:0];
    wire [2:0] tidx = {region[1], unit};
    wire req = WB_CYC_I & WB_STB_I;
    wire wr = req & WB_ACK_O & WB_WE_I;
    reg [31:0] rd_data;
    reg [31:0] old_word;

    always @* begin
        rd_data = 32'h00000000;
        case (region)
            `REG_LOGIC: begin
                case (sub)
                    `SUB_CFG: rd_data[`LCFG_W-1:0] = lg_cfg_q[unit];
                    `SUB_ONE: rd_data[`TIME_W-1:0] = lg_set_q[unit];
                    `SUB_TWO: rd_data[`TIME_W-1:0] = lg_res_q[unit];
                    default: rd_data[`TIME_W-1:0] = lg_val[unit*`TIME_W +: `TIME_W];
                endcase
            end
            `REG_TSET0, `REG_TSET1: begin
                case (sub)
                    `SUB_CFG: rd_data[`TCFG_W-1:0] = tm_cfg_q[tidx];
                    `SUB_ONE: rd_data[`TIME_W-1:0] = tm_dly_q[tidx];
                    `SUB_TWO: rd_data[`TIME_W-1:0] = tm_t1_q[tidx];
                    default: rd_data[`TIME_W-1:0] = tm_t2_q[tidx];
                endcase
            end
            default: begin
                case (unit)
                    `MISC_TVAL: rd_data[`TIME_W-1:0] = tm_val[sub*`TIME_W +: `TIME_W];
                    `MISC_FFCFG: rd_data[`FCFG_W-1:0] = ff_cfg_q[sub];
                    `MISC_CTRL: begin
                        if (sub == `CTRL_SET)
                            rd_data[0] = act_set_q;
                        else if (sub == `CTRL_STATUS)
                            rd_data[11:0] = {FLIPFLOP_OUT, TIMER_OUT, LOGIC_OUT};
                    end
                    default: rd_data = 32'h00000000;
                endcase
            end
        endcase
        old_word = rd_data;
    end

    wire [31:0] nw = merge(old_word, WB_DAT_I, WB_SEL_I);

    always @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h00000000;
        end else begin
            WB_ACK_O <= req & ~WB_ACK_O;
            if (req & ~WB_ACK_O)
                WB_DAT_O <= rd_data;
        end
    end

    integer n;
    always @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            for (n = 0; n < 4; n = n + 1) begin
                lg_cfg_q[n] <= `LCFG_RST;
                lg_set_q[n] <= `TIME_RST;
                lg_res_q[n] <= `TIME_RST;
                ff_cfg_q[n] <= `FCFG_RST;
            end
            for (n = 0; n < 8; n = n + 1) begin
                tm_cfg_q[n] <= `TCFG_RST;
                tm_dly_q[n] <= `TIME_RST;
                tm_t1_q[n] <= `TIME_RST;
                tm_t2_q[n] <= `TIME_RST;
            end
            act_set_q <= 1'b0;
        end else if (wr) begin
            case (region)
                `REG_LOGIC: begin
                    case (sub)
                        `SUB_CFG: lg_cfg_q[unit] <= nw[`LCFG_W-1:0];
                        `SUB_ONE: lg_set_q[unit] <= nw[`TIME_W-1:0];
                        `SUB_TWO: lg_res_q[unit] <= nw[`TIME_W-1:0];
                        default: ;
                    endcase
                end
                `REG_TSET0, `REG_TSET1: begin
                    case (sub)
                        `SUB_CFG: tm_cfg_q[tidx] <= nw[`TCFG_W-1:0];
                        `SUB_ONE: tm_dly_q[tidx] <= nw[`TIME_W-1:0];
                        `SUB_TWO: tm_t1_q[tidx] <= nw[`TIME_W-1:0];
                        default: tm_t2_q[tidx] <= nw[`TIME_W-1:0];
                    endcase
                end
                default: begin
                    if (unit == `MISC_FFCFG)
                        ff_cfg_q[sub] <= nw[`FCFG_W-1:0];
                    else if (unit == `MISC_CTRL && sub == `CTRL_SET)
                        act_set_q <= nw[0];
                end
            endcase
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : unit_g
            localparam [31:0] GI_INT = g;
            localparam [1:0] GI = GI_INT[1:0];
            // Logic expression unit
            wire [`LCFG_W-1:0] lc = lg_cfg_q[GI];
            wire [3:0] lv = {SIG_IN[lc[`F_LIN4]], SIG_IN[lc[`F_LIN3]],
                             SIG_IN[lc[`F_LIN2]], SIG_IN[lc[`F_LIN1]]};
            wire expr = ev_expr(lv, lc[`F_LOP1], lc[`F_LOP2], lc[`F_LOP3], lc[`F_LORD]);
            wire [`TIME_W-1:0] ldly = expr ? lg_set_q[GI] : lg_res_q[GI];
            reg lout_q;
            reg [`TIME_W-1:0] lcnt_q;
            always @(posedge CLK_SYS or negedge ARST_N) begin
                if (!ARST_N) begin
                    lout_q <= 1'b0;
                    lcnt_q <= `TIME_RST;
                end else if (expr != lout_q) begin
                    if (lcnt_q >= ldly) begin
                        lout_q <= expr;
                        lcnt_q <= `TIME_RST;
                    end else if (tick) begin
                        lcnt_q <= lcnt_q + 1'b1;
                    end
                end else begin
                    lcnt_q <= `TIME_RST;
                end
            end
            assign LOGIC_OUT[g] = lout_q;
            assign lg_val[g*`TIME_W +: `TIME_W] = lcnt_q;

            // Timer; settings follow the active set, count does not
            wire [2:0] ti = {act_set_q, GI};
            wire [1:0] mode = tm_cfg_q[ti][`F_TMODE];
            wire trig = SIG_IN[tm_cfg_q[ti][`F_TTRIG]];
            wire [`TIME_W-1:0] t1 = tm_t1_q[ti];
            wire [`TIME_W-1:0] t2 = tm_t2_q[ti];
            reg tout_q;
            reg tprev_q;
            reg [`TIME_W-1:0] tcnt_q;
            always @(posedge CLK_SYS or negedge ARST_N) begin
                if (!ARST_N) begin
                    tout_q <= 1'b0;
                    tprev_q <= 1'b0;
                    tcnt_q <= `TIME_RST;
                end else begin
                    tprev_q <= trig;
                    case (mode)
                        `TMR_DELAY: begin
                            if (!trig) begin
                                tout_q <= 1'b0;
                                tcnt_q <= `TIME_RST;
                            end else if (!tout_q) begin
                                if (tcnt_q >= tm_dly_q[ti])
                                    tout_q <= 1'b1;
                                else if (tick)
                                    tcnt_q <= tcnt_q + 1'b1;
                            end
                        end
                        `TMR_ALT: begin
                            if (!trig) begin
                                tout_q <= 1'b0;
                                tcnt_q <= `TIME_RST;
                            end else if (!tprev_q) begin
                                tout_q <= 1'b1;
                                tcnt_q <= `TIME_RST;
                            end else if (tcnt_q >= (tout_q ? t1 : t2)) begin
                                tout_q <= ~tout_q;
                                tcnt_q <= `TIME_RST;
                            end else if (tick) begin
                                tcnt_q <= tcnt_q + 1'b1;
                            end
                        end
                        `TMR_ONTIME: begin
                            if (trig && !tprev_q) begin
                                tout_q <= 1'b1;
                                tcnt_q <= `TIME_RST;
                            end else if (tout_q) begin
                                if (tcnt_q >= t1) begin
                                    if (!trig)
                                        tout_q <= 1'b0;
                                end else if (tick) begin
                                    tcnt_q <= tcnt_q + 1'b1;
                                end
                            end
                        end
                        default: begin
                            tout_q <= 1'b0;
                            tcnt_q <= `TIME_RST;
                        end
                    endcase
                end
            end
            assign TIMER_OUT[g] = tout_q;
            assign tm_val[g*`TIME_W +: `TIME_W] = tcnt_q;

            // Flip-flop, inputs sampled every 8 ms
            wire [`FCFG_W-1:0] fc = ff_cfg_q[GI];
            wire fs = SIG_IN[fc[`F_FSET]];
            wire fr = SIG_IN[fc[`F_FRES]];
            reg fs_q;
            reg fr_q;
            reg fout_q;
            wire s_rise = fs & ~fs_q;
            wire r_rise = fr & ~fr_q;
            always @(posedge CLK_SYS or negedge ARST_N) begin
                if (!ARST_N) begin
                    fs_q <= 1'b0;
                    fr_q <= 1'b0;
                    fout_q <= 1'b0;
                end else if (samp) begin
                    fs_q <= fs;
                    fr_q <= fr;
                    case (fc[`F_FMODE])
                        `FF_RESET: begin
                            if (r_rise)
                                fout_q <= 1'b0;
                            else if (s_rise && !fr)
                                fout_q <= 1'b1;
                        end
                        `FF_SET: begin
                            if (s_rise)
                                fout_q <= 1'b1;
                            else if (r_rise && !fs)
                                fout_q <= 1'b0;
                        end
                        `FF_EDGE: begin
                            if (s_rise && !r_rise)
                                fout_q <= 1'b1;
                            else if (r_rise && !s_rise)
                                fout_q <= 1'b0;
                        end
                        default: fout_q <= fout_q;
                    endcase
                end
            end
            assign FLIPFLOP_OUT[g] = fout_q;
        end
    endgenerate

endmodule

`default_nettype wire

// file: verilog/ltf_map.vh
/*
 Register map, field positions, codes and timing constants of the logic,
 timer and flip-flop block. Definitions only; included by the design file.
*/
`ifndef LTF_MAP_VH
`define LTF_MAP_VH

// Timing
`define CLK_PERIOD_NS 5
`define TICK_PERIOD_NS 100000000
`define SAMPLE_PERIOD_NS 8000000
`define TIME_W 19
`define TICK_CNT_W 25
`define SAMPLE_CNT_W 21

// Word index regions (byte address bits 7:6)
`define REG_LOGIC 2'h0
`define REG_TSET0 2'h1
`define REG_TSET1 2'h2
`define REG_MISC 2'h3

// Sub-register index within a unit (byte address bits 3:2)
`define SUB_CFG 2'h0
`define SUB_ONE 2'h1
`define SUB_TWO 2'h2
`define SUB_THREE 2'h3

// Units of the misc region (byte address bits 5:4)
`define MISC_TVAL 2'h0
`define MISC_FFCFG 2'h1
`define MISC_CTRL 2'h2
`define CTRL_SET 2'h0
`define CTRL_STATUS 2'h1

// Logic unit configuration fields
`define F_LIN1 3:0
`define F_LIN2 7:4
`define F_LIN3 11:8
`define F_LIN4 15:12
`define F_LOP1 17:16
`define F_LOP2 19:18
`define F_LOP3 21:20
`define F_LORD 24
`define LCFG_W 25
`define LCFG_RST 25'h0150000

// Timer configuration fields
`define F_TTRIG 3:0
`define F_TMODE 5:4
`define TCFG_W 6
`define TCFG_RST 6'h00

// Flip-flop configuration fields
`define F_FSET 3:0
`define F_FRES 7:4
`define F_FMODE 9:8
`define FCFG_W 10
`define FCFG_RST 10'h000

// Codes
`define OP_END 2'h0
`define OP_AND 2'h1
`define OP_OR 2'h2
`define OP_XOR 2'h3
`define ORDER_CHAIN 1'b0
`define TMR_OFF 2'h0
`define TMR_DELAY 2'h1
`define TMR_ALT 2'h2
`define TMR_ONTIME 2'h3
`define FF_RESET 2'h0
`define FF_SET 2'h1
`define FF_EDGE 2'h2

`define TIME_RST 19'h00000
`endif
